//--- hdl/link_diag_control_regs.sv
// Diagnostic and control register bank: parity limit, channel watchdog, serial input conditioning.
// Notes on behaviour
// - Per-port fault flag when count reaches limit.
// - Limit high byte from high register.
// - Limit low byte from low register.
// - Watchdog aborts transactions exceeding the timeout.
// - Timeout field bits 7:1, 2 ms steps.
// - Off bit 0 stops the watchdog.
// - Remote block bit drops remote register writes.
// - Remote block leaves target forwarding untouched.
// - SDA input hold, 50 ns steps.
// - Glitch filter on SCL/SDA, 5 ns steps.
// - Count parity errors only while checker enabled.
`timescale 1ns/10ps
module link_diag_control_regs
  import link_diag_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = WD_TICK_CYCLES_DEF
)
(
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Register access from the local target or the control channel.
  input wire reg_req_t reg_req_in,
  output reg_rsp_t reg_rsp_out,
  // Parity checker events and counter control.
  input wire logic parity_check_en_in,
  input wire logic [NUM_PORTS-1:0] parity_err_in,
  input wire logic [NUM_PORTS-1:0] parity_clr_in,
  output logic [NUM_PORTS-1:0] parity_fault_out,
  // Control channel transaction tracking.
  input wire logic txn_active_in,
  output logic txn_abort_out,
  output logic bus_release_out,
  // Serial bus pins, conditioned copies out.
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  output logic scl_clean_out,
  output logic sda_clean_out
);

  // Converts a count of units of a given length to whole cycles, rounding up.
  function automatic logic [7:0] units_to_cycles(input logic [3:0] units, input int unit_ns);
    int total;
    total = (int'(units) * unit_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    units_to_cycles = total[7:0];
  endfunction

  // Register storage.
  logic [7:0] parity_limit_high_byte_reg;
  logic [7:0] parity_limit_low_byte_reg;
  logic [7:0] channel_timeout_control_reg;
  logic [7:0] serial_bus_input_control_reg;
  // Decoded fields.
  logic [15:0] parity_fault_limit;
  logic [6:0] channel_timeout_value;
  logic channel_timeout_off;
  logic remote_block;
  logic [7:0] hold_cycles;
  logic [7:0] filter_cycles;
  // A write is taken unless it comes from the far side while blocked.
  logic write_ok;

  assign parity_fault_limit = {parity_limit_high_byte_reg,
    parity_limit_low_byte_reg};
  assign channel_timeout_value =
    channel_timeout_control_reg[TIMEOUT_VAL_MSB:TIMEOUT_VAL_LSB];
  assign channel_timeout_off = channel_timeout_control_reg[TIMEOUT_OFF_BIT];
  assign remote_block = serial_bus_input_control_reg[REMOTE_BLOCK_BIT];
  assign hold_cycles = units_to_cycles({1'b0,
    serial_bus_input_control_reg[SDA_HOLD_MSB:SDA_HOLD_LSB]}, HOLD_UNIT_NS);
  assign filter_cycles = units_to_cycles(serial_bus_input_control_reg[FILTER_MSB:FILTER_LSB],
    FILTER_UNIT_NS);
  // Only this bank's own writes are gated; forwarding to attached targets is not seen here.
  assign write_ok = reg_req_in.valid && reg_req_in.write
    && !(reg_req_in.remote && remote_block);

  // Register writes; a blocked remote write leaves every register untouched.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      parity_limit_high_byte_reg <= RST_LIMIT_HI;
      parity_limit_low_byte_reg <= RST_LIMIT_LO;
      channel_timeout_control_reg <= RST_TIMEOUT_CTL;
      serial_bus_input_control_reg <= RST_BUS_IN_CTL;
    end
    else if (write_ok)
    begin
      // All four registers are full 8-bit read/write fields.
      case (reg_req_in.addr)
        ADDR_LIMIT_HI: parity_limit_high_byte_reg <= reg_req_in.wdata;
        ADDR_LIMIT_LO: parity_limit_low_byte_reg <= reg_req_in.wdata;
        ADDR_TIMEOUT_CTL: channel_timeout_control_reg <= reg_req_in.wdata;
        ADDR_BUS_IN_CTL: serial_bus_input_control_reg <= reg_req_in.wdata;
        default: ; // Writes outside the bank are dropped.
      endcase
    end
  end

  // Read answer, one cycle after the request; unmapped offsets read as zero.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      reg_rsp_out <= '0;
    end
    else
    begin
      reg_rsp_out.valid <= reg_req_in.valid && !reg_req_in.write;
      case (reg_req_in.addr)
        ADDR_LIMIT_HI: reg_rsp_out.rdata <= parity_limit_high_byte_reg;
        ADDR_LIMIT_LO: reg_rsp_out.rdata <= parity_limit_low_byte_reg;
        ADDR_TIMEOUT_CTL: reg_rsp_out.rdata <= channel_timeout_control_reg;
        ADDR_BUS_IN_CTL: reg_rsp_out.rdata <= serial_bus_input_control_reg;
        default: reg_rsp_out.rdata <= 8'h00;
      endcase
    end
  end

  // Per-port parity error counters and fault flags.
  logic [15:0] parity_count_reg [NUM_PORTS];

  // Counters saturate so a limit once reached cannot be lost to a wrap.
  // A clear and an error in the same cycle leave a count of one, so the event is kept.
  always_ff @(posedge core_clk_in)
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (rst_in)
      begin
        parity_count_reg[p] <= 16'h0000;
      end
      else if (parity_clr_in[p])
      begin
        parity_count_reg[p] <= {15'h0000, parity_err_in[p] & parity_check_en_in};
      end
      else if (parity_err_in[p] && parity_check_en_in && parity_count_reg[p] != 16'hFFFF)
      begin
        parity_count_reg[p] <= parity_count_reg[p] + 16'h0001;
      end
    end
  end

  // Fault flags compare each count with the full 16-bit limit, independently per port.
  always_ff @(posedge core_clk_in)
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (rst_in)
      begin
        parity_fault_out[p] <= 1'b0;
      end
      else
      begin
        parity_fault_out[p] <= parity_count_reg[p] >= parity_fault_limit;
      end
    end
  end

  // Watchdog: a prescaler makes one tick per timeout unit, a unit counter counts ticks.
  wd_state_t wd_state_reg;
  logic [15:0] tick_count_reg;
  logic [6:0] unit_count_reg;
  logic tick;

  assign tick = (tick_count_reg == 16'(TICK_CYCLES - 1));

  // Prescaler restarts with each transaction so every timeout spans whole units.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || wd_state_reg != WD_RUN || tick)
    begin
      tick_count_reg <= 16'h0000;
    end
    else
    begin
      tick_count_reg <= tick_count_reg + 16'h0001;
    end
  end

  // Unit counter counts elapsed units during a running transaction.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || wd_state_reg != WD_RUN)
    begin
      unit_count_reg <= 7'h00;
    end
    else if (tick && unit_count_reg != 7'h7F)
    begin
      unit_count_reg <= unit_count_reg + 7'h01;
    end
  end

  // Watchdog sequencing. A zero timeout, which software is told to avoid, expires
  // at the first tick rather than hanging, the safer of the two readings.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      wd_state_reg <= WD_IDLE;
    end
    else
    begin
      case (wd_state_reg)
        WD_IDLE:
        begin
          // Arm only when a transaction runs and the watchdog is not switched off.
          if (txn_active_in && !channel_timeout_off)
          begin
            wd_state_reg <= WD_RUN;
          end
        end
        WD_RUN:
        begin
          if (!txn_active_in || channel_timeout_off)
          begin
            wd_state_reg <= WD_IDLE;
          end
          else if (tick && (unit_count_reg + 7'h01 >= channel_timeout_value
            || channel_timeout_value == 7'h00))
          begin
            wd_state_reg <= WD_EXPIRE;
          end
        end
        WD_EXPIRE:
        begin
          // One cycle of abort, then back to idle ready for a new transaction.
          wd_state_reg <= WD_IDLE;
        end
        default: wd_state_reg <= WD_IDLE;
      endcase
    end
  end

  // Abort and bus release pulse together for the single expiry cycle.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      txn_abort_out <= 1'b0;
      bus_release_out <= 1'b0;
    end
    else
    begin
      txn_abort_out <= (wd_state_reg == WD_EXPIRE);
      bus_release_out <= (wd_state_reg == WD_EXPIRE);
    end
  end

  // Pin synchronisers; index 0 is SCL, index 1 is SDA.
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] pin_filt_reg;
  logic [7:0] filt_count_reg [2];
  logic [HOLD_TAPS-1:0] sda_delay_reg;

  // Two flops before any logic looks at the pins.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      pin_meta_reg <= 2'h3;
      pin_sync_reg <= 2'h3;
    end
    else
    begin
      pin_meta_reg <= {sda_pin_in, scl_pin_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Glitch filter: a new level is taken only after it outlasts the filter depth.
  // Resolution is one clock, so the depth rounds up to whole 50 ns cycles.
  always_ff @(posedge core_clk_in)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (rst_in)
      begin
        pin_filt_reg[i] <= 1'b1;
        filt_count_reg[i] <= 8'h00;
      end
      else if (pin_sync_reg[i] == pin_filt_reg[i])
      begin
        filt_count_reg[i] <= 8'h00;
      end
      else if (filt_count_reg[i] >= filter_cycles)
      begin
        pin_filt_reg[i] <= pin_sync_reg[i];
        filt_count_reg[i] <= 8'h00;
      end
      else
      begin
        filt_count_reg[i] <= filt_count_reg[i] + 8'h01;
      end
    end
  end

  // SDA hold: the filtered SDA is delayed by the hold setting so it lags SCL.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      sda_delay_reg <= '1;
    end
    else
    begin
      sda_delay_reg <= {sda_delay_reg[HOLD_TAPS-2:0], pin_filt_reg[1]};
    end
  end

  // Conditioned outputs from flops.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      scl_clean_out <= 1'b1;
      sda_clean_out <= 1'b1;
    end
    else
    begin
      scl_clean_out <= pin_filt_reg[0];
      if (hold_cycles == 8'h00)
      begin
        sda_clean_out <= pin_filt_reg[1];
      end
      else
      begin
        sda_clean_out <= sda_delay_reg[hold_cycles[2:0] - 3'h1];
      end
    end
  end

endmodule

//--- include/link_diag_pkg.sv
// Package holding register map, field layout, reset values and timing for the diag bank.
package link_diag_pkg;
  // Register offsets on the device register port.
  localparam logic [7:0] ADDR_LIMIT_HI = 8'h05;
  localparam logic [7:0] ADDR_LIMIT_LO = 8'h06;
  localparam logic [7:0] ADDR_TIMEOUT_CTL = 8'h07;
  localparam logic [7:0] ADDR_BUS_IN_CTL = 8'h08;
  // Reset values of the four registers.
  localparam logic [7:0] RST_LIMIT_HI = 8'h01;
  localparam logic [7:0] RST_LIMIT_LO = 8'h00;
  localparam logic [7:0] RST_TIMEOUT_CTL = 8'hFE;
  localparam logic [7:0] RST_BUS_IN_CTL = 8'h1C;
  // Field positions.
  localparam int TIMEOUT_VAL_MSB = 7;
  localparam int TIMEOUT_VAL_LSB = 1;
  localparam int TIMEOUT_OFF_BIT = 0;
  localparam int REMOTE_BLOCK_BIT = 7;
  localparam int SDA_HOLD_MSB = 6;
  localparam int SDA_HOLD_LSB = 4;
  localparam int FILTER_MSB = 3;
  localparam int FILTER_LSB = 0;
  // Structure sizes.
  localparam int NUM_PORTS = 4;
  localparam int HOLD_TAPS = 8;
  // Timing: clock period, watchdog unit, hold unit and filter unit.
  localparam int CLK_PERIOD_NS = 50;
  localparam int WD_UNIT_MS = 2;
  localparam int HOLD_UNIT_NS = 50;
  localparam int FILTER_UNIT_NS = 5;
  localparam int WD_TICK_CYCLES_DEF = (WD_UNIT_MS * 1000000) / CLK_PERIOD_NS;
  // Register access request and answer.
  typedef struct packed {
    logic valid;
    logic write;
    logic remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } reg_rsp_t;
  // Watchdog states, one-hot.
  typedef enum logic [2:0] {
    WD_IDLE = 3'b001,
    WD_RUN = 3'b010,
    WD_EXPIRE = 3'b100
  } wd_state_t;
endpackage

//--- testbench/link_diag_checker_sva.sv
// Port-level assertions for the diagnostic and control register bank.
`timescale 1ns/10ps
module link_diag_checker_sva
  import link_diag_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = WD_TICK_CYCLES_DEF
)
(
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Register port.
  input wire reg_req_t reg_req_in,
  input wire reg_rsp_t reg_rsp_out,
  // Parity and watchdog.
  input wire logic [NUM_PORTS-1:0] parity_err_in,
  input wire logic [NUM_PORTS-1:0] parity_clr_in,
  input wire logic [NUM_PORTS-1:0] parity_fault_out,
  input wire logic txn_active_in,
  input wire logic txn_abort_out,
  input wire logic bus_release_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Shadow of the limit and block bit, so that read data can be judged.
  logic [15:0] lim_reg;
  logic blk_reg;
  logic wr_ok;
  // A remote write while blocked must leave the shadow alone too.
  assign wr_ok = reg_req_in.valid && reg_req_in.write && !(reg_req_in.remote && blk_reg);
  // Shadow follows accepted writes only.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      lim_reg <= 16'h0100;
      blk_reg <= 1'b0;
    end
    else if (wr_ok && reg_req_in.addr == ADDR_LIMIT_HI)
      lim_reg[15:8] <= reg_req_in.wdata;
    else if (wr_ok && reg_req_in.addr == ADDR_LIMIT_LO)
      lim_reg[7:0] <= reg_req_in.wdata;
    else if (wr_ok && reg_req_in.addr == ADDR_BUS_IN_CTL)
      blk_reg <= reg_req_in.wdata[REMOTE_BLOCK_BIT];
  end
  sequence s_read(logic [7:0] a);
    reg_req_in.valid && !reg_req_in.write && reg_req_in.addr == a;
  endsequence
  // Clear of port 0 with no error, then a non-zero limit.
  sequence s_clear0;
    parity_clr_in[0] && !parity_err_in[0] ##1 lim_reg != 16'h0000;
  endsequence
  chk_read_answer: assert property (
    reg_req_in.valid && !reg_req_in.write |=> reg_rsp_out.valid)
    else $error("read not answered in the next cycle");
  chk_write_silent: assert property (
    reg_req_in.valid && reg_req_in.write |=> !reg_rsp_out.valid)
    else $error("write produced an answer");
  chk_hi_byte_read: assert property (
    s_read(ADDR_LIMIT_HI) |=> reg_rsp_out.rdata == lim_reg[15:8])
    else $error("limit high byte read wrong");
  chk_lo_byte_read: assert property (
    s_read(ADDR_LIMIT_LO) |=> reg_rsp_out.rdata == lim_reg[7:0])
    else $error("limit low byte read wrong");
  chk_block_bit_read: assert property (
    s_read(ADDR_BUS_IN_CTL) |=> reg_rsp_out.rdata[7] == blk_reg)
    else $error("remote block bit read wrong");
  chk_fault_cleared: assert property (s_clear0 |=> !parity_fault_out[0])
    else $error("fault flag stayed after clear");
  chk_abort_paired: assert property (txn_abort_out |-> bus_release_out)
    else $error("abort without bus release");
  chk_abort_single: assert property (txn_abort_out |=> !txn_abort_out)
    else $error("abort pulse longer than one cycle");
  chk_abort_not_early: assert property (
    $rose(txn_active_in) |=> !txn_abort_out [*3])
    else $error("abort too soon after transaction start");
endmodule
bind link_diag_control_regs link_diag_checker_sva #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
  .reg_rsp_out(reg_rsp_out), .parity_err_in(parity_err_in), .parity_clr_in(parity_clr_in),
  .parity_fault_out(parity_fault_out), .txn_active_in(txn_active_in),
  .txn_abort_out(txn_abort_out), .bus_release_out(bus_release_out));

//--- testbench/remote_serializer_model.sv
// Behavioural model of the remote serializer on the control channel.
`timescale 1ns/10ps
module remote_serializer_model
  import link_diag_pkg::*;
(
  // Clock.
  input wire logic core_clk_in,
  // Requests and transaction level toward the bank.
  output reg_req_t req_out,
  output logic txn_active_out
);
  initial
  begin
    req_out = '0;
    txn_active_out = 1'b0;
  end
  // One remote write; a zero timeout is sent as one, which expires at the first tick just as zero does.
  task automatic rwrite(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ADDR_TIMEOUT_CTL && v[7:1] == 7'h00)
      v[7:1] = 7'h01;
    @(negedge core_clk_in);
    req_out = {3'b111, a, v};
    @(negedge core_clk_in);
    req_out = '0;
  endtask
  // Raise or drop the transaction-in-progress level.
  task automatic txn(input logic on);
    @(negedge core_clk_in);
    txn_active_out = on;
  endtask
endmodule

//--- testbench/tb_link_diag_control_regs.sv
// Self-checking bench for the diagnostic and control register bank.
`timescale 1ns/10ps
module tb_link_diag_control_regs
  import link_diag_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  reg_req_t loc_req = '0;
  reg_req_t rmt_req;
  reg_req_t req_mux;
  reg_rsp_t rsp;
  logic par_en = 1'b1;
  logic [3:0] par_err = '0;
  logic [3:0] par_clr = '0;
  logic [3:0] fault;
  logic txn_on;
  logic abort_p;
  logic rel_p;
  logic scl = 1'b1;
  logic sda = 1'b1;
  logic scl_c;
  logic sda_c;
  int fail_count = 0;
  int n_checks = 0;
  int ns;
  int nd;
  logic seen;
  logic [7:0] ra [5] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h3F};
  logic [7:0] rv [5] = '{8'h01, 8'h00, 8'hFE, 8'h1C, 8'h00};
  // Remote requests take the port while valid.
  assign req_mux = rmt_req.valid ? rmt_req : loc_req;
  remote_serializer_model rmt (.core_clk_in(core_clk_in), .req_out(rmt_req),
    .txn_active_out(txn_on));
  link_diag_control_regs #(.TICK_CYCLES(4)) dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .reg_req_in(req_mux), .reg_rsp_out(rsp), .parity_check_en_in(par_en),
    .parity_err_in(par_err), .parity_clr_in(par_clr), .parity_fault_out(fault),
    .txn_active_in(txn_on), .txn_abort_out(abort_p), .bus_release_out(rel_p),
    .scl_pin_in(scl), .sda_pin_in(sda), .scl_clean_out(scl_c), .sda_clean_out(sda_c));
  initial
  begin
    forever #25 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Local read: request for one edge, answer seen in the following cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk_in);
    loc_req = {3'b100, a, 8'h00};
    @(negedge core_clk_in);
    loc_req = '0;
    chk("rsp_valid", 8'h01, {7'h00, rsp.valid});
    chk("rdata", exp, rsp.rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    loc_req = {3'b110, a, d};
    @(negedge core_clk_in);
    loc_req = '0;
  endtask
  // Drops both pins together and counts falling edges until each clean copy follows.
  task automatic edge_lat(output int ls, output int ld);
    ls = 0;
    ld = 0;
    scl = 1'b0;
    sda = 1'b0;
    for (int i = 1; i < 20; i++)
    begin
      @(negedge core_clk_in);
      if (!scl_c && ls == 0)
        ls = i;
      if (!sda_c && ld == 0)
        ld = i;
    end
    // Back to idle, long enough for the deepest hold to drain.
    scl = 1'b1;
    sda = 1'b1;
    repeat (12) @(negedge core_clk_in);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // A hang is cut short well beyond the expected run, which the saturation test dominates.
  initial
  begin
    #(50 * 80000);
    fail_count++;
    give_verdict();
  end
  initial
  begin
    repeat (16) @(negedge core_clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 5; i++)
      rd(ra[i], rv[i]);
    $display("test reset values done");
    // One-cycle glitch is rejected at the default filter depth.
    seen = 1'b0;
    @(negedge core_clk_in);
    scl = 1'b0;
    @(negedge core_clk_in);
    scl = 1'b1;
    repeat (12)
    begin
      @(negedge core_clk_in);
      seen = seen | !scl_c;
    end
    chk("glitch", 8'h00, {7'h00, seen});
    edge_lat(ns, nd);
    chk("scl_latency_ok", 8'h01, {7'h00, ns >= 4 && ns <= 10});
    chk("sda_hold", 8'(ns + 1), 8'(nd));
    // No filtering and the longest hold: two sync flops, one filter flop, one output flop.
    wr(8'h08, 8'h70);
    edge_lat(ns, nd);
    chk("scl_no_filter", 8'h04, 8'(ns));
    chk("sda_hold_max", 8'(ns + 7), 8'(nd));
    // A zero hold lets SDA follow in step with SCL.
    wr(8'h08, 8'h00);
    edge_lat(ns, nd);
    chk("sda_hold_zero", 8'(ns), 8'(nd));
    wr(8'h08, 8'h1C);
    $display("test pins done");
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h03);
    rd(8'h06, 8'h03);
    for (int i = 0; i < 3; i++)
    begin
      @(negedge core_clk_in);
      par_err = 4'h1;
    end
    @(negedge core_clk_in);
    par_err = 4'h0;
    repeat (3) @(negedge core_clk_in);
    chk("fault", 8'h01, {4'h0, fault});
    @(negedge core_clk_in);
    par_clr = 4'h1;
    par_en = 1'b0;
    @(negedge core_clk_in);
    par_clr = 4'h0;
    par_err = 4'h1;
    repeat (3) @(negedge core_clk_in);
    par_err = 4'h0;
    repeat (3) @(negedge core_clk_in);
    chk("fault_disabled", 8'h00, {4'h0, fault});
    par_en = 1'b1;
    // A wrapping counter would fall below the top limit after 65536 errors.
    wr(8'h05, 8'hFF);
    wr(8'h06, 8'hFF);
    @(negedge core_clk_in);
    par_err = 4'h2;
    repeat (65540) @(negedge core_clk_in);
    par_err = 4'h0;
    repeat (3) @(negedge core_clk_in);
    chk("fault_saturated", 8'h02, {4'h0, fault});
    $display("test parity done");
    wr(8'h08, 8'h9C);
    rmt.rwrite(8'h05, 8'h77);
    rd(8'h05, 8'hFF);
    wr(8'h08, 8'h1C);
    rmt.rwrite(8'h05, 8'h77);
    rd(8'h05, 8'h77);
    $display("test remote block done");
    wr(8'h07, 8'h04);
    rmt.txn(1'b1);
    ns = 0;
    while (!abort_p && ns < 40)
    begin
      @(negedge core_clk_in);
      ns++;
    end
    chk("abort_time_ok", 8'h01, {7'h00, ns >= 8 && ns <= 16});
    chk("release", 8'h01, {7'h00, rel_p});
    rmt.txn(1'b0);
    wr(8'h07, 8'h05);
    rmt.txn(1'b1);
    seen = 1'b0;
    repeat (30)
    begin
      @(negedge core_clk_in);
      seen = seen | abort_p;
    end
    rmt.txn(1'b0);
    chk("abort_off", 8'h00, {7'h00, seen});
    $display("test watchdog done");
    give_verdict();
  end
endmodule
